// >>> rtl/aiaf_top.sv
// Amplifier indirect access bridge with DC guard and fault flags
`timescale 1ns/1ps

module aiaf_top
  import aiaf_pkg::*;
#(
  parameter int DC_SHORT_LIMIT = DC_SHORT_CYC,
  parameter int DC_LONG_LIMIT = DC_LONG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic amp_xfer_start,
  output logic amp_xfer_write,
  output logic [7:0] amp_xfer_addr,
  output logic [7:0] amp_xfer_len,
  output logic [23:0] amp_xfer_data,
  input wire logic amp_rd_valid,
  input wire logic [15:0] amp_rd_data,
  input wire logic pwm_pos,
  input wire logic pwm_neg,
  input wire logic [5:0] amp_fault_evt,
  input wire logic [7:0] sys_event_in,
  output logic amp_shutdown,
  output logic amp_fault_pin_n,
  output logic sys_fault_pin_n,
  output logic [31:0] dsp_mode,
  output logic [7:0] rom_run
);

  // ****************************************
  // Declarations
  // ****************************************
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rd_mux;
  logic wr_acc;
  logic [15:0] idx;
  logic [7:0] wbyte;
  logic [31:0] dsp_mode_reg;
  logic [7:0] rom_run_reg;
  logic [7:0] tgt_addr_reg;
  logic [7:0] xfer_len_reg;
  logic [7:0] tgt_sel_reg;
  logic [23:0] data_reg;
  logic [15:0] rd_result_reg;
  aiaf_arm_e arm_reg;
  logic start_reg;
  logic xwrite_reg;
  logic [7:0] xlen_reg;
  logic [3:0] dc_guard_reg;
  logic [5:0] amp_flag_reg;
  logic dc_fault_reg;
  logic [7:0] sys_flag_reg;
  logic amp_pin_n_reg;
  logic sys_pin_n_reg;
  logic [SINC_LOG2-1:0] sinc_cnt_reg;
  logic signed [9:0] sinc_acc_reg;
  logic signed [9:0] sinc_sum;
  logic [8:0] sinc_mag;
  logic [8:0] lvl;
  logic dc_over_reg;
  logic [29:0] persist_reg;
  logic [29:0] persist_lim;
  logic dc_guard_enable;
  logic cmd_go;
  logic rd_go;
  logic data_wr;

  // Register index match
  function automatic logic hit(input logic [15:0] a,
                               input logic [15:0] i);
    hit = (a == i);
  endfunction

  assign idx = avs_address[17:2];
  assign wbyte = avs_writedata[7:0];
  assign wr_acc = avs_write && !wait_reg && avs_byteenable[0];
  assign dc_guard_enable = dc_guard_reg[DC_GUARD_ENABLE_BIT];

  // ****************************************
  // Avalon-MM slave handshake
  // ****************************************

  // One wait cycle, then acknowledge for one cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 1'b1;
    end else if ((avs_read || avs_write) && wait_reg) begin
      wait_reg <= 1'b0;
    end else begin
      wait_reg <= 1'b1;
    end
  end

  // Read data mux, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0;
    if (hit(idx, IDX_DSP_MODE)) begin
      rd_mux = dsp_mode_reg;
    end else if (hit(idx, IDX_AMP_FAULT)) begin
      rd_mux = {24'h0, 1'b0, dc_fault_reg, amp_flag_reg};
    end else if (hit(idx, IDX_DC_GUARD)) begin
      rd_mux = {28'h0, dc_guard_reg};
    end else if (hit(idx, IDX_ROM_RUN)) begin
      rd_mux = {24'h0, rom_run_reg};
    end else if (hit(idx, IDX_SYS_EVT)) begin
      rd_mux = {24'h0, sys_flag_reg};
    end else if (hit(idx, IDX_TGT_ADDR)) begin
      rd_mux = {24'h0, tgt_addr_reg};
    end else if (hit(idx, IDX_XFER_LEN)) begin
      rd_mux = {24'h0, xfer_len_reg};
    end else if (hit(idx, IDX_XFER_DATA)) begin
      rd_mux = {16'h0, rd_result_reg};
    end else if (hit(idx, IDX_TGT_SEL)) begin
      rd_mux = {24'h0, tgt_sel_reg};
    end
  end

  // Read data captured as wait drops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= rd_mux;
    end
  end

  // ****************************************
  // Plain control registers
  // ****************************************

  // DSP mode word with byte enables
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dsp_mode_reg <= 32'h0;
    end else if (avs_write && !wait_reg &&
                 hit(idx, IDX_DSP_MODE)) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          dsp_mode_reg[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end
    end
  end

  // ROM run control
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rom_run_reg <= 8'h0;
    end else if (wr_acc && hit(idx, IDX_ROM_RUN)) begin
      rom_run_reg <= wbyte;
    end
  end

  // DC guard control, upper bits reserved
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_guard_reg <= DC_GUARD_RST;
    end else if (wr_acc && hit(idx, IDX_DC_GUARD)) begin
      dc_guard_reg <= wbyte[3:0];
    end
  end

  // ****************************************
  // Indirect staging
  // ****************************************
  assign cmd_go = wr_acc && hit(idx, IDX_XFER_CMD) &&
                  wbyte == CMD_WRITE && tgt_sel_reg == TGT_AMP;
  assign data_wr = wr_acc && hit(idx, IDX_XFER_DATA);
  assign rd_go = data_wr && arm_reg == ARM_READ &&
                 (wbyte == RD_ONE || wbyte == RD_TWO) &&
                 tgt_sel_reg == TGT_AMP;

  // Target select, address and length hold their values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgt_sel_reg <= 8'h0;
      tgt_addr_reg <= 8'h0;
      xfer_len_reg <= 8'h0;
    end else if (wr_acc) begin
      if (hit(idx, IDX_TGT_SEL)) begin
        tgt_sel_reg <= wbyte;
      end
      if (hit(idx, IDX_TGT_ADDR)) begin
        tgt_addr_reg <= wbyte;
      end
      if (hit(idx, IDX_XFER_LEN)) begin
        xfer_len_reg <= wbyte;
      end
    end
  end

  // Data bytes shift in, first byte ends most significant
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      data_reg <= 24'h0;
    end else if (data_wr && !rd_go) begin
      data_reg <= {data_reg[15:0], wbyte};
    end
  end

  // Readback armed by a write command, any other accepted write disarms
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      arm_reg <= ARM_IDLE;
    end else if (cmd_go) begin
      arm_reg <= ARM_READ;
    end else if (wr_acc) begin
      arm_reg <= ARM_IDLE;
    end
  end

  // Transfer request toward the amplifier register portion
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      start_reg <= 1'b0;
      xwrite_reg <= 1'b0;
      xlen_reg <= 8'h0;
    end else begin
      start_reg <= cmd_go || rd_go;
      if (cmd_go) begin
        xwrite_reg <= 1'b1;
        xlen_reg <= xfer_len_reg;
      end else if (rd_go) begin
        xwrite_reg <= 1'b0;
        xlen_reg <= wbyte;
      end
    end
  end

  // Returned readback value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_result_reg <= 16'h0;
    end else if (amp_rd_valid) begin
      rd_result_reg <= amp_rd_data;
    end
  end

  // ****************************************
  // DC detection
  // ****************************************
  assign sinc_sum = sinc_acc_reg +
                    ((pwm_pos && !pwm_neg) ? 10'sd1 :
                     (pwm_neg && !pwm_pos) ? -10'sd1 : 10'sd0);
  assign sinc_mag = sinc_sum[9] ? 9'(-sinc_sum) : 9'(sinc_sum);

  // Level selected by threshold code
  always_comb begin
    case (dc_guard_reg[DC_TH_LSB +: 2])
      TH_12P5: lvl = LVL_12P5;
      TH_18P75: lvl = LVL_18P75;
      TH_25: lvl = LVL_25;
      default: lvl = 9'h1ff;
    endcase
  end

  // Sinc window over the PWM difference
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sinc_cnt_reg <= '0;
      sinc_acc_reg <= 10'sd0;
      dc_over_reg <= 1'b0;
    end else if (!dc_guard_enable) begin
      sinc_cnt_reg <= '0;
      sinc_acc_reg <= 10'sd0;
      dc_over_reg <= 1'b0;
    end else begin
      sinc_cnt_reg <= sinc_cnt_reg + 1'b1;
      if (&sinc_cnt_reg) begin
        sinc_acc_reg <= 10'sd0;
        dc_over_reg <= dc_guard_reg[DC_TH_LSB +: 2] != 2'h0 &&
                       sinc_mag >= lvl;
      end else begin
        sinc_acc_reg <= sinc_sum;
      end
    end
  end

  assign persist_lim = dc_guard_reg[DC_TIME_BIT] ?
                       30'(DC_LONG_LIMIT) : 30'(DC_SHORT_LIMIT);

  // Persistence count of cycles spent under an over-level verdict
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      persist_reg <= 30'h0;
    end else if (!dc_guard_enable || !dc_over_reg) begin
      persist_reg <= 30'h0;
    end else if (persist_reg < persist_lim) begin
      persist_reg <= persist_reg + 30'h1;
    end
  end

  // DC latch, only reset clears it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_fault_reg <= 1'b0;
    end else if (dc_guard_enable && persist_reg >= persist_lim) begin
      dc_fault_reg <= 1'b1;
    end
  end

  // ****************************************
  // Sticky fault flags
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_amp_flag
      // Set wins over a write of zero
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          amp_flag_reg[g] <= 1'b0;
        end else if (amp_fault_evt[g]) begin
          amp_flag_reg[g] <= 1'b1;
        end else if (wr_acc && hit(idx, IDX_AMP_FAULT) &&
                     !wbyte[g]) begin
          amp_flag_reg[g] <= 1'b0;
        end
      end
    end
    for (g = 0; g < 8; g++) begin : g_sys_flag
      // Set wins over a write of zero
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          sys_flag_reg[g] <= 1'b0;
        end else if (sys_event_in[g]) begin
          sys_flag_reg[g] <= 1'b1;
        end else if (wr_acc && hit(idx, IDX_SYS_EVT) &&
                     !wbyte[g]) begin
          sys_flag_reg[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Fault pins low while any flag stands
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      amp_pin_n_reg <= 1'b1;
      sys_pin_n_reg <= 1'b1;
    end else begin
      amp_pin_n_reg <= !(|amp_flag_reg || dc_fault_reg);
      sys_pin_n_reg <= !(|sys_flag_reg);
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign amp_xfer_start = start_reg;
  assign amp_xfer_write = xwrite_reg;
  assign amp_xfer_addr = tgt_addr_reg;
  assign amp_xfer_len = xlen_reg;
  assign amp_xfer_data = data_reg;
  assign amp_shutdown = dc_fault_reg;
  assign amp_fault_pin_n = amp_pin_n_reg;
  assign sys_fault_pin_n = sys_pin_n_reg;
  assign dsp_mode = dsp_mode_reg;
  assign rom_run = rom_run_reg;

endmodule

// >>> shared/aiaf_pkg.sv
// Constants for the amplifier indirect access and fault block
package aiaf_pkg;

  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [15:0] IDX_DSP_MODE = 16'h0000;
  localparam logic [15:0] IDX_AMP_FAULT = 16'h0010;
  localparam logic [15:0] IDX_DC_GUARD = 16'h0014;
  localparam logic [15:0] IDX_ROM_RUN = 16'hff01;
  localparam logic [15:0] IDX_SYS_EVT = 16'hff03;
  localparam logic [15:0] IDX_TGT_ADDR = 16'hff40;
  localparam logic [15:0] IDX_XFER_LEN = 16'hff41;
  localparam logic [15:0] IDX_XFER_DATA = 16'hff42;
  localparam logic [15:0] IDX_XFER_CMD = 16'hff43;
  localparam logic [15:0] IDX_TGT_SEL = 16'hff45;

  // ****************************************
  // Codes
  // ****************************************
  localparam logic [7:0] TGT_AMP = 8'h18;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] RD_ONE = 8'h01;
  localparam logic [7:0] RD_TWO = 8'h02;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam logic [3:0] DC_GUARD_RST = 4'h8;
  localparam int DC_TH_LSB = 2;
  localparam int DC_TIME_BIT = 1;
  localparam int DC_GUARD_ENABLE_BIT = 0;
  localparam int FLAG_DC_BIT = 6;
  localparam logic [1:0] TH_12P5 = 2'h1;
  localparam logic [1:0] TH_18P75 = 2'h2;
  localparam logic [1:0] TH_25 = 2'h3;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DC_TIME_SHORT_MS = 342;
  localparam int DC_TIME_LONG_MS = 684;
  localparam int DC_SHORT_CYC = DC_TIME_SHORT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int DC_LONG_CYC = DC_TIME_LONG_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SINC_LOG2 = 8;
  localparam int SINC_LEN = 1 << SINC_LOG2;
  localparam logic [8:0] LVL_12P5 = 9'(SINC_LEN >> 3);
  localparam logic [8:0] LVL_18P75 = 9'((SINC_LEN * 3) >> 4);
  localparam logic [8:0] LVL_25 = 9'(SINC_LEN >> 2);

  // Readback arming after a write command
  typedef enum logic {ARM_IDLE, ARM_READ} aiaf_arm_e;

endpackage

// >>> test/aiaf_amp_model.sv
// Behavioural model of the amplifier register portion
`timescale 1ns/1ps
module aiaf_amp_model (
  input wire logic clk,
  input wire logic amp_xfer_start,
  input wire logic amp_xfer_write,
  input wire logic [7:0] amp_xfer_addr,
  input wire logic [7:0] amp_xfer_len,
  input wire logic [23:0] amp_xfer_data,
  output logic amp_rd_valid,
  output logic [15:0] amp_rd_data
);
  logic [15:0] mem [256];
  int dly = 1;
  initial begin
    amp_rd_valid = 1'b0;
    amp_rd_data = 16'h0;
  end
  // Store writes; answer readbacks after dly cycles, then scramble data
  always @(posedge clk) begin
    if (amp_xfer_start === 1'b1) begin
      if (amp_xfer_write) begin
        mem[amp_xfer_addr] <= (amp_xfer_len == 8'h01) ?
          {8'h00, amp_xfer_data[7:0]} : amp_xfer_data[15:0];
      end else begin
        repeat (dly) @(posedge clk);
        amp_rd_data <= mem[amp_xfer_addr];
        amp_rd_valid <= 1'b1;
        @(posedge clk);
        amp_rd_valid <= 1'b0;
        amp_rd_data <= ~amp_rd_data;
      end
    end
  end
endmodule

// >>> test/aiaf_chk_assertions.sv
// Port checker for the amplifier access bridge
`timescale 1ns/1ps
module aiaf_chk
  import aiaf_pkg::*;
#(
  parameter int DC_SHORT_LIMIT = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [17:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic amp_xfer_start,
  input wire logic amp_xfer_write,
  input wire logic [7:0] amp_xfer_addr,
  input wire logic [7:0] amp_xfer_len,
  input wire logic pwm_pos,
  input wire logic pwm_neg,
  input wire logic [5:0] amp_fault_evt,
  input wire logic [7:0] sys_event_in,
  input wire logic amp_shutdown,
  input wire logic amp_fault_pin_n,
  input wire logic sys_fault_pin_n,
  input wire logic [31:0] dsp_mode
);
  logic acc;
  logic [15:0] idx;
  logic [31:0] dc_run_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Accepted write and its register index
  assign acc = avs_write && !avs_waitrequest;
  assign idx = avs_address[17:2];
  // Cycles of unbroken output imbalance
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dc_run_reg <= '0;
    end else begin
      dc_run_reg <= (pwm_pos != pwm_neg) ? dc_run_reg + 1 : '0;
    end
  end
  start_by_cmd_a: assert property (
    amp_xfer_start && amp_xfer_write |-> $past(acc && idx == IDX_XFER_CMD
    && avs_writedata[7:0] == CMD_WRITE)) else $error("stray start");
  start_once_a: assert property (
    amp_xfer_start |=> !amp_xfer_start) else $error("long start");
  readback_len_a: assert property (
    amp_xfer_start && !amp_xfer_write |-> $past(acc && idx == IDX_XFER_DATA)
    && amp_xfer_len == $past(avs_writedata[7:0])) else $error("bad readback");
  addr_hold_a: assert property (
    !$past(acc && idx == IDX_TGT_ADDR) |-> $stable(amp_xfer_addr))
    else $error("address moved");
  mode_write_a: assert property (
    acc && idx == IDX_DSP_MODE && avs_byteenable == 4'hf
    |=> dsp_mode == $past(avs_writedata)) else $error("mode not taken");
  dc_latch_a: assert property (
    amp_shutdown |=> amp_shutdown) else $error("shutdown released");
  dc_pin_low_a: assert property (
    amp_shutdown |-> ##[0:2] !amp_fault_pin_n) else $error("dc pin high");
  dc_persist_a: assert property (
    $rose(amp_shutdown) |-> dc_run_reg >= DC_SHORT_LIMIT)
    else $error("dc too soon");
  amp_pin_a: assert property (
    |amp_fault_evt |-> ##[1:3] !amp_fault_pin_n) else $error("amp pin high");
  sys_pin_a: assert property (
    |sys_event_in |-> ##[1:3] !sys_fault_pin_n) else $error("sys pin high");
endmodule
bind aiaf_top aiaf_chk #(.DC_SHORT_LIMIT(DC_SHORT_LIMIT)) u_chk (
  .clk, .sys_rst, .avs_address, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .amp_xfer_start, .amp_xfer_write,
  .amp_xfer_addr, .amp_xfer_len, .pwm_pos, .pwm_neg, .amp_fault_evt,
  .sys_event_in, .amp_shutdown, .amp_fault_pin_n, .sys_fault_pin_n,
  .dsp_mode);

// >>> test/tb_top.sv
// Self-checking bench for the amplifier access bridge
`timescale 1ns/1ps
module tb_top;
  import aiaf_pkg::*;
  localparam int SLIM = 20;
  localparam int LLIM = 40;
  // Amplifier writes: address, length, data
  localparam logic [39:0] SEQ [12] = '{
    40'h40_01_000080, 40'h64_01_000039, 40'h65_01_000011,
    40'h15_01_000060, 40'h0a_01_000009, 40'h20_02_000180,
    40'h07_01_000037, 40'h30_03_01c007, 40'h31_03_01c007,
    40'h05_01_000090, 40'h05_01_000094, 40'h05_01_00009c};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [17:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic pwm_pos = 1'b0;
  logic pwm_neg = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [1:0] pmode = 2'd0;
  logic [3:0] pc = 4'h0;
  logic [5:0] amp_fault_evt = '0;
  logic [7:0] sys_event_in = '0;
  logic [31:0] avs_readdata, dsp_mode, rd;
  logic avs_waitrequest, amp_xfer_start, amp_xfer_write, amp_rd_valid;
  logic amp_shutdown, amp_fault_pin_n, sys_fault_pin_n;
  logic [7:0] amp_xfer_addr, amp_xfer_len, rom_run;
  logic [23:0] amp_xfer_data;
  logic [15:0] amp_rd_data;
  logic [40:0] st;
  int n_mismatch = 0;
  int comparisons = 0;
  int n_start = 0;
  int n_rv = 0;
  int t;
  aiaf_top #(.DC_SHORT_LIMIT(SLIM), .DC_LONG_LIMIT(LLIM)) DUT (
    .clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .amp_xfer_start, .amp_xfer_write, .amp_xfer_addr, .amp_xfer_len,
    .amp_xfer_data, .amp_rd_valid, .amp_rd_data, .pwm_pos, .pwm_neg,
    .amp_fault_evt, .sys_event_in, .amp_shutdown, .amp_fault_pin_n,
    .sys_fault_pin_n, .dsp_mode, .rom_run);
  aiaf_amp_model u_amp (.clk, .amp_xfer_start, .amp_xfer_write,
    .amp_xfer_addr, .amp_xfer_len, .amp_xfer_data, .amp_rd_valid,
    .amp_rd_data);
  always #5 clk = ~clk;
  // PWM stimulus: idle, steady imbalance, or 9 of 16 cycles high
  always @(posedge clk) begin
    pc <= pc + 4'h1;
    pwm_pos <= pmode == 2'd1 || (pmode == 2'd2 && pc < 4'd9);
    pwm_neg <= pmode == 2'd2 && pc >= 4'd9;
  end
  // Record transfers and readback answers
  always @(posedge clk) begin
    if (amp_xfer_start === 1'b1) begin
      n_start <= n_start + 1;
      st <= {amp_xfer_write, amp_xfer_addr, amp_xfer_len, amp_xfer_data};
    end
    if (amp_rd_valid === 1'b1) n_rv <= n_rv + 1;
  end
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [15:0] a,
                     input logic [31:0] d);
    avs_address <= {a, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    chk(48'(rd), 48'(e));
  endtask
  task automatic acc5(input logic [39:0] s);
    bus(1'b1, IDX_TGT_SEL, 32'(TGT_AMP));
    bus(1'b1, IDX_TGT_ADDR, 32'(s[39:32]));
    bus(1'b1, IDX_XFER_LEN, 32'(s[31:24]));
    for (int i = 2; i >= 0; i--) begin
      if (i < s[31:24]) bus(1'b1, IDX_XFER_DATA, 32'(s[8*i +: 8]));
    end
    bus(1'b1, IDX_XFER_CMD, 32'(CMD_WRITE));
  endtask
  task automatic xchk(input logic w, input logic [39:0] s, input int n);
    logic [23:0] m;
    m = w ? (24'h1 << (8 * s[31:24])) - 24'h1 : 24'h0;
    @(posedge clk);
    chk(48'(n_start), 48'(n));
    chk(48'({st[40:24], st[23:0] & m}), 48'({w, s & {16'hffff, m}}));
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200us;
    n_mismatch++;
    end_sim();
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(48'({amp_shutdown, amp_fault_pin_n, sys_fault_pin_n}), 48'h3);
    rdc(IDX_DC_GUARD, 32'(DC_GUARD_RST));
    rdc(IDX_AMP_FAULT, '0);
    rdc(IDX_SYS_EVT, '0);
    bus(1'b1, IDX_ROM_RUN, 32'h1);
    chk(48'(rom_run), 48'h1);
    foreach (SEQ[i]) begin
      acc5(SEQ[i]);
      xchk(1'b1, SEQ[i], i + 1);
    end
    // Readback of two and one bytes, quick then slow far side
    for (int k = 0; k < 2; k++) begin
      u_amp.dly = k * 6;
      acc5(SEQ[5 + k]);
      xchk(1'b1, SEQ[5 + k], 13 + 2 * k);
      t = n_rv;
      bus(1'b1, IDX_XFER_DATA, 32'(2 - k));
      xchk(1'b0, {SEQ[5 + k][39:24], 24'h0}, 14 + 2 * k);
      while (n_rv == t) @(posedge clk);
      rdc(IDX_XFER_DATA, 32'(SEQ[5 + k][15:0]));
    end
    bus(1'b1, IDX_XFER_CMD, 32'h1);
    bus(1'b1, IDX_TGT_SEL, 32'h17);
    bus(1'b1, IDX_XFER_CMD, 32'(CMD_WRITE));
    rdc(IDX_TGT_SEL, 32'h17);
    rdc(16'h0123, '0);
    chk(48'(n_start), 48'h10);
    avs_byteenable <= 4'he;
    bus(1'b1, IDX_TGT_ADDR, 32'h99);
    avs_byteenable <= 4'hf;
    rdc(IDX_TGT_ADDR, 32'(SEQ[6][39:32]));
    bus(1'b1, IDX_DSP_MODE, 32'h02037800);
    rdc(IDX_DSP_MODE, 32'h02037800);
    bus(1'b1, IDX_DSP_MODE, 32'h06037800);
    chk(48'(dsp_mode), 48'h06037800);
    amp_fault_evt <= 6'h3f;
    sys_event_in <= 8'hff;
    @(posedge clk);
    amp_fault_evt <= '0;
    sys_event_in <= '0;
    rdc(IDX_AMP_FAULT, 32'h3f);
    rdc(IDX_SYS_EVT, 32'hff);
    chk(48'({amp_fault_pin_n, sys_fault_pin_n}), '0);
    bus(1'b1, IDX_AMP_FAULT, 32'h1);
    bus(1'b1, IDX_SYS_EVT, 32'h0f);
    rdc(IDX_AMP_FAULT, 32'h1);
    rdc(IDX_SYS_EVT, 32'h0f);
    bus(1'b1, IDX_AMP_FAULT, '0);
    bus(1'b1, IDX_SYS_EVT, '0);
    rdc(IDX_AMP_FAULT, '0);
    chk(48'({amp_fault_pin_n, sys_fault_pin_n}), 48'h3);
    // Imbalance of 32 per window stays under the 18.75 percent level
    pmode <= 2'd2;
    bus(1'b1, IDX_DC_GUARD, 32'h09);
    repeat (800) @(posedge clk);
    chk(48'(amp_shutdown), '0);
    // Steady imbalance: disabled, then unusable threshold
    pmode <= 2'd1;
    bus(1'b1, IDX_DC_GUARD, 32'h0c);
    repeat (800) @(posedge clk);
    chk(48'(amp_shutdown), '0);
    bus(1'b1, IDX_DC_GUARD, 32'h01);
    repeat (800) @(posedge clk);
    chk(48'(amp_shutdown), '0);
    // Live: steady at 25 percent long time, then 12.5 percent short time
    for (int k = 0; k < 2; k++) begin
      pmode <= 2'(1 + k);
      bus(1'b1, IDX_DC_GUARD, k ? 32'h05 : 32'h0f);
      t = 0;
      while (amp_shutdown !== 1'b1 && t < 900) begin
        @(posedge clk);
        t++;
      end
      chk(48'(t >= (k ? SLIM : LLIM) && t < 900), 48'h1);
      bus(1'b1, IDX_AMP_FAULT, '0);
      rdc(IDX_AMP_FAULT, 32'h40);
      chk(48'({amp_shutdown, amp_fault_pin_n}), 48'h2);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rdc(IDX_AMP_FAULT, '0);
    end
    pmode <= 2'd0;
    end_sim();
  end
endmodule
